// [hpc_consts.svh]
// Purpose: Constants of the host port pin control block
// Assumes: Pin bus index 0 is port B bit 8, index 7 is port B bit 15
// Notes: Definitions only
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// =====================================================
// Pin bus geometry
`define HPC_PIN_W 8
`define HPC_ADDR_W 3
`define HPC_ADDR_LO 0
`define HPC_ADDR_HI 2
`define HPC_PIN_RW 3
`define HPC_PIN_STROBE 4
`define HPC_PIN_SELECT 5
`define HPC_PIN_REQ 6
`define HPC_PIN_ACK 7

// =====================================================
// Reset values and pin levels
`define HPC_PINS_RST 8'h00
`define HPC_ADDR_RST 3'h0
`define HPC_PIN_ACTIVE 1'b0
`define HPC_SYNC_STAGES 2

`endif

// [hpc_pkg.sv]
// Purpose: Types shared by the host port pin control block
// Assumes: Nothing beyond the constants header
// Notes: Types only
`default_nettype none

package hpc_pkg;
   // Register select carried by the three address pins
   typedef logic [2:0] hpc_addr_t;
   // Strobe configuration of the host bus
   typedef enum logic {HPC_SINGLE_STROBE, HPC_DUAL_STROBE} hpc_strobe_t;
endpackage

`default_nettype wire

// [hpc_sync.sv]
// Purpose: Two flip-flop synchroniser for the host port pins
// Assumes: Inputs are asynchronous to i_ref_clk
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
`include "hpc_consts.svh"

module hpc_sync
   import hpc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [`HPC_PIN_W-1:0] i_async,
   output logic [`HPC_PIN_W-1:0] o_sync
);

   // First stage, metastability catcher
   logic [`HPC_PIN_W-1:0] meta_q;

   // =====================================================
   // Synchroniser stages
   // Pins idle high, so reset to all ones
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         meta_q <= ~`HPC_PINS_RST;
         o_sync <= ~`HPC_PINS_RST;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

`default_nettype wire

// [hpc_pin_ctrl.sv]
// Purpose: Pin control of an 8-bit parallel host port, port B bits 8..15
// Assumes: Strobes, select and acknowledge are active low pins
// Notes: Request pins are open drain, pulled high outside the chip
`timescale 1ns/1ns
`default_nettype none
`include "hpc_consts.svh"

module hpc_pin_ctrl
   import hpc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_host_port_en,
   input wire logic i_dual_strobe,
   input wire logic i_request_mode_select,
   input wire logic i_service_req,
   input wire logic i_tx_req,
   input wire logic i_rx_req,
   input wire logic [`HPC_PIN_W-1:0] i_gpio_dout,
   input wire logic [`HPC_PIN_W-1:0] i_gpio_dir,
   input wire logic [`HPC_PIN_W-1:0] i_pin_b,
   output logic [`HPC_PIN_W-1:0] o_pin_b,
   output logic [`HPC_PIN_W-1:0] o_pin_b_oe,
   output logic [`HPC_PIN_W-1:0] o_gpio_din,
   output logic o_xfer_start,
   output logic o_xfer_read,
   output logic [`HPC_ADDR_W-1:0] o_xfer_addr,
   output logic o_host_ack
);

   // =====================================================
   // Synchronised pins
   logic [`HPC_PIN_W-1:0] pin_s; // Pins after two flops
   hpc_strobe_t strobe_cfg; // Strobe configuration
   logic sel_act; // Chip select asserted
   logic wr_act; // Write access active
   logic rd_act; // Read access active
   logic acc_act; // Any access active
   logic acc_prev_q; // Access active one cycle ago

   hpc_sync u_sync
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_pin_b),
      .o_sync(pin_s)
   );

   // =====================================================
   // Access decode
   // Turns strobe, select and read/write pins into access levels
   always_comb
   begin
      strobe_cfg = hpc_strobe_t'(i_dual_strobe);
      sel_act = i_host_port_en &&
                (pin_s[`HPC_PIN_SELECT] == `HPC_PIN_ACTIVE);
      if (strobe_cfg == HPC_SINGLE_STROBE)
      begin
         // strobe with select, direction from pin
         wr_act = sel_act &&
                  (pin_s[`HPC_PIN_STROBE] == `HPC_PIN_ACTIVE) &&
                  !pin_s[`HPC_PIN_RW];
         rd_act = sel_act &&
                  (pin_s[`HPC_PIN_STROBE] == `HPC_PIN_ACTIVE) &&
                  pin_s[`HPC_PIN_RW];
      end
      else
      begin
         wr_act = sel_act &&
                  (pin_s[`HPC_PIN_STROBE] == `HPC_PIN_ACTIVE);
         rd_act = sel_act &&
                  (pin_s[`HPC_PIN_RW] == `HPC_PIN_ACTIVE);
      end
      acc_act = wr_act || rd_act;
   end

   // =====================================================
   // Transfer start
   // One pulse on the leading edge of each qualified access
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         acc_prev_q <= 1'b0;
         o_xfer_start <= 1'b0;
         o_xfer_read <= 1'b0;
         o_xfer_addr <= `HPC_ADDR_RST;
      end
      else
      begin
         acc_prev_q <= acc_act;
         o_xfer_start <= acc_act && !acc_prev_q;
         if (acc_act && !acc_prev_q)
         begin
            o_xfer_read <= rd_act;
            o_xfer_addr <= pin_s[`HPC_ADDR_HI:`HPC_ADDR_LO];
         end
      end
   end

   // =====================================================
   // Acknowledge input
   // acknowledge is an input only in request mode 0
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_host_ack <= 1'b0;
      end
      else
      begin
         o_host_ack <= i_host_port_en && !i_request_mode_select &&
                       (pin_s[`HPC_PIN_ACK] == `HPC_PIN_ACTIVE);
      end
   end

   // =====================================================
   // Pin drivers
   // Host mode drives only the request pin, plus the ack pin in request mode 1; GPIO mode follows direction
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_pin_b <= `HPC_PINS_RST;
         o_pin_b_oe <= `HPC_PINS_RST;
      end
      else if (!i_host_port_en)
      begin
         // each pin is a GPIO bit
         o_pin_b <= i_gpio_dout;
         o_pin_b_oe <= i_gpio_dir;
      end
      else
      begin
         o_pin_b <= `HPC_PINS_RST;
         o_pin_b_oe <= `HPC_PINS_RST;
         if (!i_request_mode_select)
         begin
            o_pin_b_oe[`HPC_PIN_REQ] <= i_service_req;
         end
         else
         begin
            o_pin_b_oe[`HPC_PIN_REQ] <= i_tx_req;
            o_pin_b_oe[`HPC_PIN_ACK] <= i_rx_req;
         end
      end
   end

   // =====================================================
   // GPIO read back
   // Pin levels are always visible to the port B data path
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         o_gpio_din <= `HPC_PINS_RST;
      end
      else
      begin
         o_gpio_din <= pin_s;
      end
   end

   // =====================================================
   // Checks
   chk_start_needs_select: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_xfer_start |-> $past(sel_act))
      else $error("transfer started without chip select");

   chk_dual_write_strobe: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_dual_strobe && sel_act && !pin_s[`HPC_PIN_STROBE] &&
       pin_s[`HPC_PIN_RW] && !acc_prev_q)
      |=> o_xfer_start && !o_xfer_read)
      else $error("dual strobe write not started");

   chk_dual_read_strobe: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_dual_strobe && sel_act && !pin_s[`HPC_PIN_RW] &&
       pin_s[`HPC_PIN_STROBE] && !acc_prev_q)
      |=> o_xfer_start && o_xfer_read)
      else $error("dual strobe read not started");

   // Reset in the launch cycle keeps the outputs cleared, so skip it
   chk_mode0_request: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_rst_n && i_host_port_en && !i_request_mode_select)
      |=> o_pin_b_oe[`HPC_PIN_REQ] == $past(i_service_req) &&
          !o_pin_b[`HPC_PIN_REQ] && !o_pin_b_oe[`HPC_PIN_ACK])
      else $error("service request pin wrong");

   chk_mode1_tx_rx: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_rst_n && i_host_port_en && i_request_mode_select)
      |=> o_pin_b_oe[`HPC_PIN_REQ] == $past(i_tx_req) &&
          o_pin_b_oe[`HPC_PIN_ACK] == $past(i_rx_req))
      else $error("transmit or receive request pin wrong");

   chk_ack_mode_gate: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_request_mode_select |=> !o_host_ack)
      else $error("acknowledge seen in request mode 1");

   chk_reset_release: assert property (
      @(posedge i_ref_clk)
      !i_rst_n |=> o_pin_b_oe == `HPC_PINS_RST && !o_xfer_start)
      else $error("pins driven during reset");

   chk_gpio_follow: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (i_rst_n && !i_host_port_en)
      |=> o_pin_b_oe == $past(i_gpio_dir) &&
                          o_pin_b == $past(i_gpio_dout) && !o_xfer_start)
      else $error("gpio mode pins not following port B");

   chk_single_dir: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!i_dual_strobe && acc_act && !acc_prev_q)
      |=> o_xfer_read == $past(pin_s[`HPC_PIN_RW]))
      else $error("single strobe direction wrong");

   chk_addr_capture: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (acc_act && !acc_prev_q)
      |=> o_xfer_addr == $past(pin_s[`HPC_ADDR_HI:`HPC_ADDR_LO]))
      else $error("register select not captured");

endmodule

`default_nettype wire

// [hpc_host_model.sv]
// Purpose: Host side of the port B pins with wire resolution
// Assumes: Request and ack lines are pulled up outside the chip
// Notes: Undriven plain lines flip each cycle
`timescale 1ns/1ns
`default_nettype none
`include "hpc_consts.svh"

module hpc_host_model
   import hpc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [`HPC_PIN_W-1:0] i_dev_val,
   input wire logic [`HPC_PIN_W-1:0] i_dev_oe,
   input wire logic [`HPC_PIN_W-1:0] i_host_val,
   input wire logic [`HPC_PIN_W-1:0] i_host_oe,
   output logic [`HPC_PIN_W-1:0] o_pin
);
   // ==========================================
   // Floating lines
   // Inverse of last level, so a released line never looks held
   logic [`HPC_PIN_W-1:0] float_q = 8'h00;

   // Flip the floating pattern every cycle
   always_ff @(posedge i_ref_clk)
   begin
      float_q <= ~o_pin;
   end

   // ==========================================
   // Wire resolution
   // pull-up on request and ack lines
   assign o_pin = (i_dev_oe & i_dev_val)
      | (~i_dev_oe & i_host_oe & i_host_val)
      | (~i_dev_oe & ~i_host_oe & {2'b11, float_q[5:0]});
endmodule

`default_nettype wire

// [hpc_pin_ctrl_tb_top.sv]
// Purpose: Self-checking bench of the host port pin control
// Assumes: Host pins driven through the host model
// Notes: Inputs change at rising edges by non-blocking assignment
`timescale 1ns/1ns
`default_nettype none
`include "hpc_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
error_cnt++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module hpc_pin_ctrl_tb_top
   import hpc_pkg::*;
;
   // ==========================================
   // Stimulus and observed signals
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, dual = 1'b0;
   logic rmode = 1'b0, sreq = 1'b1, treq = 1'b0, rreq = 1'b0;
   logic [7:0] gdout = 8'h00, gdir = 8'h00;
   logic [7:0] hval = 8'hff, hoe = 8'hbf;
   logic [7:0] pin, pout, poe, gdin;
   logic xstart, xread, host_ack_in;
   logic [2:0] xaddr;
   int error_cnt = 0, n_checks = 0, cyc = 0;

   always #2 clk = ~clk;

   hpc_host_model host (.i_ref_clk(clk), .i_dev_val(pout),
      .i_dev_oe(poe), .i_host_val(hval), .i_host_oe(hoe), .o_pin(pin));

   hpc_pin_ctrl DUT (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_host_port_en(en), .i_dual_strobe(dual),
      .i_request_mode_select(rmode), .i_service_req(sreq),
      .i_tx_req(treq), .i_rx_req(rreq), .i_gpio_dout(gdout),
      .i_gpio_dir(gdir), .i_pin_b(pin), .o_pin_b(pout),
      .o_pin_b_oe(poe), .o_gpio_din(gdin), .o_xfer_start(xstart),
      .o_xfer_read(xread), .o_xfer_addr(xaddr), .o_host_ack(host_ack_in));

   // ==========================================
   // Closing report
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         print_verdict();
      end
   end

   // One host access; stb and idl are pin bits 4:3
   // select and address held for the whole strobe
   task automatic access(input logic [2:0] a, input logic [1:0] stb,
      input logic [1:0] idl, input logic cs_n, input logic go,
      input logic rd);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      hval <= {2'b11, cs_n, stb, a};
      repeat (6)
      begin
         @(posedge clk);
         #1;
         if (xstart === 1'b1) seen = 1'b1;
      end
      `CHK("start", go, seen)
      if (go)
      begin
         `CHK("read", rd, xread)
         `CHK("addr", a, xaddr)
      end
      @(posedge clk);
      hval <= {3'b111, idl, a};
      repeat (4) @(posedge clk);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_single();
      dual <= 1'b0;
      access(3'h5, 2'b01, 2'b11, 1'b0, 1'b1, 1'b1);
      access(3'h0, 2'b00, 2'b10, 1'b0, 1'b1, 1'b0);
      access(3'h7, 2'b01, 2'b11, 1'b1, 1'b0, 1'b0);
      $display("test single done");
   endtask

   task automatic t_dual();
      dual <= 1'b1;
      access(3'h3, 2'b01, 2'b11, 1'b0, 1'b1, 1'b0);
      access(3'h6, 2'b10, 2'b11, 1'b0, 1'b1, 1'b1);
      access(3'h2, 2'b01, 2'b11, 1'b1, 1'b0, 1'b0);
      $display("test dual done");
   endtask

   task automatic t_req();
      rmode <= 1'b0;
      sreq <= 1'b1;
      hval[7] <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      `CHK("oe76", 2'b01, poe[7:6])
      `CHK("req", 1'b0, pin[6])
      `CHK("ack", 1'b1, host_ack_in)
      @(posedge clk);
      sreq <= 1'b0;
      rmode <= 1'b1;
      hoe <= 8'h3f;
      treq <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("tx", 2'b01, poe[7:6])
      @(posedge clk);
      treq <= 1'b0;
      rreq <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      `CHK("rx", 2'b10, poe[7:6])
      `CHK("ack1", 1'b0, host_ack_in)
      @(posedge clk);
      rreq <= 1'b0;
      rmode <= 1'b0;
      hoe <= 8'hbf;
      hval[7] <= 1'b1;
      $display("test requests done");
   endtask

   // Mid-run reset must release a request pin that was driven
   task automatic t_reset();
      @(posedge clk);
      sreq <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("pre_rst", 1'b1, poe[6])
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("mid_oe", 8'h00, poe)
      `CHK("mid_out", 8'h00, pout)
      @(posedge clk);
      rst_n <= 1'b1;
      sreq <= 1'b0;
      repeat (2) @(posedge clk);
      $display("test reset done");
   endtask

   task automatic t_gpio();
      @(posedge clk);
      en <= 1'b0;
      dual <= 1'b0;
      gdir <= 8'h0f;
      gdout <= 8'ha5;
      hoe <= 8'hf0;
      hval <= 8'h00;
      repeat (8) @(posedge clk);
      #1;
      `CHK("oe", 8'h0f, poe)
      `CHK("out", 4'h5, pout[3:0])
      `CHK("din", 8'h05, gdin)
      `CHK("nostart", 1'b0, xstart)
      $display("test gpio done");
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      `CHK("rst_oe", 8'h00, poe)
      `CHK("rst_ack", 1'b0, host_ack_in)
      @(posedge clk);
      rst_n <= 1'b1;
      sreq <= 1'b0;
      repeat (4) @(posedge clk);
      t_single();
      t_dual();
      t_req();
      t_reset();
      t_gpio();
      print_verdict();
   end
endmodule

`default_nettype wire
